// [dsbs_pkg.sv]
/*
 * Shared constants of the stop and DC brake sequencer: parameter indices,
 * reset values, value limits, fixed frequencies and timing counts.
 * Assumes a single 125 MHz core clock; frequencies are in 0.1 Hz units.
 */
`default_nettype none

package dsbs_pkg;

    // Parameter indices, equal to their numeric identifiers.
    localparam logic [7:0] STOP_BEH_IDX    = 8'h85;
    localparam logic [7:0] BRAKE_FN_IDX    = 8'h99;
    localparam logic [7:0] BRAKE_DUR_IDX   = 8'h9A;
    localparam logic [7:0] BRAKE_VOLT_IDX  = 8'h9B;
    localparam logic [7:0] BRAKE_ONSET_IDX = 8'h9C;
    localparam logic [7:0] STATUS_IDX      = 8'h80;

    // Reset values.
    localparam logic [15:0] STOP_BEH_RST    = 16'h0001;
    localparam logic [15:0] BRAKE_FN_RST    = 16'h0000;
    localparam logic [15:0] BRAKE_DUR_RST   = 16'h0000;
    localparam logic [15:0] BRAKE_VOLT_RST  = 16'h0000;
    localparam logic [15:0] BRAKE_ONSET_RST = 16'h0000;

    // Highest legal value of each setting; duration is in 0.1 s units.
    localparam logic [15:0] STOP_BEH_MAX  = 16'h0001;
    localparam logic [15:0] BRAKE_FN_MAX  = 16'h0003;
    localparam logic [15:0] BRAKE_DUR_MAX = 16'h0064;
    localparam logic [15:0] PCT_MAX       = 16'h0064;

    // Brake function field: bit 0 brakes on stop, bit 1 before start.
    localparam int FN_STOP_BIT  = 0;
    localparam int FN_START_BIT = 1;

    // Stop behaviour field value for a ramped stop.
    localparam logic STOP_RAMPED = 1'b1;

    // Frequencies in 0.1 Hz units.
    localparam logic [15:0] FIXED_FREQ_DHZ = 16'h00C8;
    localparam logic [15:0] SPAN_50_DHZ    = 16'h01F4;
    localparam logic [15:0] SPAN_60_DHZ    = 16'h0258;

    // Selector value that hands control to the terminals.
    localparam logic [3:0] CTRL_SRC_TERMINAL = 4'h0;
    localparam logic [3:0] TERM_FN_DEFAULT   = 4'h0;

    // Timing: one tenth of a second in core clock cycles.
    localparam int CLK_PERIOD_NS = 8;
    localparam int TENTH_S_NS    = 100_000_000;
    localparam int CYC_PER_DS    = TENTH_S_NS / CLK_PERIOD_NS;

    // Run sequence states.
    typedef enum logic [2:0] {
        ST_IDLE       = 3'b000,
        ST_PRE_BRAKE  = 3'b001,
        ST_RUN        = 3'b010,
        ST_RAMP_DOWN  = 3'b011,
        ST_STOP_BRAKE = 3'b100
    } dsbs_state_t;

endpackage

`default_nettype wire

// [dsbs_ramp_tick.sv]
/*
 * Fractional rate generator for the frequency ramps: pulses tick so that
 * step_num steps are spread evenly over period_den clock cycles.
 * Assumes step_num is below 2**16 and period_den fits ACC_W bits.
 */
`timescale 1ns/1ps
`default_nettype none

module dsbs_ramp_tick #(
    parameter int ACC_W = 40
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             enable,
    input  wire logic [15:0]      step_num,
    input  wire logic [ACC_W-1:0] period_den,
    output logic                  tick
);

    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;
    logic [ACC_W-1:0] acc_sum;

    // Accumulate the step count each cycle; a tick spends one period.
    // Clearing while idle stops a stale remainder from firing early.
    always_comb
    begin
        acc_sum = acc_reg + ACC_W'(step_num);
        tick    = enable && (acc_sum >= period_den);
        if (!enable)
            acc_next = '0;
        else if (tick)
            acc_next = acc_sum - period_den;
        else
            acc_next = acc_sum;
    end

    // Accumulator register.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            acc_reg <= '0;
        else
            acc_reg <= acc_next;
    end

endmodule

`default_nettype wire

// [dsbs_sequencer.sv]
/*
 * Stop and DC brake sequencer of a variable speed drive, with decoding of
 * the run, fault and fixed-speed terminals and the five brake parameters.
 * Assumes terminal inputs synchronous to core_clk; parameters are written
 * and read by index through a simple strobe port.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - With ramped stop selected, removing the run command ramps to 0 Hz.
// - With coasting stop selected, removing the run command cuts output.
// - Brake function 0 is off, 1 on stop, 2 before start, 3 both.
// - DC braking lasts the programmed time, 0 to 10 s.
// - The brake level is 0 to 100 percent of the rated motor voltage.
// - A ramped stop hands over to braking at the onset frequency.
// - A coasting stop brakes at once and ignores the onset frequency.
// - Clockwise is unsigned, counterclockwise is a negative frequency.
// - Under terminal control, clockwise and counterclockwise run inputs both high switch off.
// - The fault input must be high to run; low switches the drive off.
// - The first fixed-speed input runs at 20 Hz, ignoring the analog.
// - The analog reference spans zero up to 50 or 60 Hz.
// - Selectors at 0 take commands and setpoints from the terminals.
// - The configuration module acts only with control source 0.
module dsbs_sequencer #(
    parameter int REF_W      = 10,
    parameter int CYC_PER_DS = dsbs_pkg::CYC_PER_DS
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             par_wr_en,
    input  wire logic             par_rd_en,
    input  wire logic [7:0]       par_addr,
    input  wire logic [15:0]      par_wr_data,
    output logic [15:0]           par_rd_data,
    output logic                  par_rd_valid,
    input  wire logic             run_clockwise,
    input  wire logic             run_counterclockwise,
    input  wire logic             external_fault_input,
    input  wire logic             fixed_speed_one,
    input  wire logic [REF_W-1:0] analog_ref,
    input  wire logic             span_60hz,
    input  wire logic [15:0]      accel_time_ds,
    input  wire logic [15:0]      decel_time_ds,
    input  wire logic [3:0]       ctrl_source,
    input  wire logic [3:0]       terminal_function,
    input  wire logic             cfg_module_present,
    input  wire logic [3:0]       cfg_mode_switch,
    input  wire logic             remote_run,
    input  wire logic             remote_ccw,
    input  wire logic [15:0]      remote_freq_dhz,
    output logic                  drive_enable,
    output logic signed [16:0]    out_freq_dhz,
    output logic                  dc_brake_on,
    output logic [6:0]            dc_brake_volt_pct,
    output logic [2:0]            drive_state
);

    localparam int ACC_W = 48;

    // Short local names for the run states; the codes live in the package.
    localparam dsbs_pkg::dsbs_state_t ST_IDLE       = dsbs_pkg::ST_IDLE;
    localparam dsbs_pkg::dsbs_state_t ST_PRE_BRAKE  = dsbs_pkg::ST_PRE_BRAKE;
    localparam dsbs_pkg::dsbs_state_t ST_RUN        = dsbs_pkg::ST_RUN;
    localparam dsbs_pkg::dsbs_state_t ST_RAMP_DOWN  = dsbs_pkg::ST_RAMP_DOWN;
    localparam dsbs_pkg::dsbs_state_t ST_STOP_BRAKE = dsbs_pkg::ST_STOP_BRAKE;

    // Parameter store.
    logic [15:0] stop_behaviour_reg, stop_behaviour_next;
    logic [15:0] dc_brake_function_reg, dc_brake_function_next;
    logic [15:0] dc_brake_duration_reg, dc_brake_duration_next;
    logic [15:0] dc_brake_voltage_pct_reg, dc_brake_voltage_pct_next;
    logic [15:0] dc_brake_onset_freq_pct_reg, dc_brake_onset_freq_pct_next;
    logic [15:0] rd_data_reg, rd_data_next;
    logic        rd_valid_reg, rd_valid_next;

    // Sequencer state.
    dsbs_pkg::dsbs_state_t st_reg, st_next;
    logic [15:0]        freq_reg, freq_next;
    logic               ccw_reg, ccw_next;
    logic [31:0]        pre_reg, pre_next;
    logic [15:0]        ds_reg, ds_next;
    logic               en_out_reg, en_out_next;
    logic               brk_out_reg, brk_out_next;
    logic signed [16:0] fout_reg, fout_next;

    // Decoded controls.
    logic             term_ctl, run_req, kill, dir_req;
    logic [3:0]       eff_term_fn;
    logic [15:0]      span, target, goal;
    logic             brake_stop, brake_start, ramped, at_onset;
    logic             braking, brake_done, ramp_en, ramp_tick, ramp_up;
    logic [ACC_W-1:0] ramp_den;

    // Parameter writes; out-of-range values are dropped, not clamped.
    always_comb
    begin
        stop_behaviour_next          = stop_behaviour_reg;
        dc_brake_function_next       = dc_brake_function_reg;
        dc_brake_duration_next       = dc_brake_duration_reg;
        dc_brake_voltage_pct_next    = dc_brake_voltage_pct_reg;
        dc_brake_onset_freq_pct_next = dc_brake_onset_freq_pct_reg;
        if (par_wr_en)
        begin
            unique case (par_addr)
                dsbs_pkg::STOP_BEH_IDX:
                    if (par_wr_data <= dsbs_pkg::STOP_BEH_MAX)
                        stop_behaviour_next = par_wr_data;
                dsbs_pkg::BRAKE_FN_IDX:
                    if (par_wr_data <= dsbs_pkg::BRAKE_FN_MAX)
                        dc_brake_function_next = par_wr_data;
                dsbs_pkg::BRAKE_DUR_IDX:
                    if (par_wr_data <= dsbs_pkg::BRAKE_DUR_MAX)
                        dc_brake_duration_next = par_wr_data;
                dsbs_pkg::BRAKE_VOLT_IDX:
                    if (par_wr_data <= dsbs_pkg::PCT_MAX)
                        dc_brake_voltage_pct_next = par_wr_data;
                dsbs_pkg::BRAKE_ONSET_IDX:
                    if (par_wr_data <= dsbs_pkg::PCT_MAX)
                        dc_brake_onset_freq_pct_next = par_wr_data;
                default: ;
            endcase
        end
        // Reads answer one cycle later; unknown indices read zero.
        rd_valid_next = par_rd_en;
        rd_data_next  = rd_data_reg;
        if (par_rd_en)
        begin
            unique case (par_addr)
                dsbs_pkg::STOP_BEH_IDX:    rd_data_next = stop_behaviour_reg;
                dsbs_pkg::BRAKE_FN_IDX:    rd_data_next = dc_brake_function_reg;
                dsbs_pkg::BRAKE_DUR_IDX:   rd_data_next = dc_brake_duration_reg;
                dsbs_pkg::BRAKE_VOLT_IDX:
                    rd_data_next = dc_brake_voltage_pct_reg;
                dsbs_pkg::BRAKE_ONSET_IDX:
                    rd_data_next = dc_brake_onset_freq_pct_reg;
                dsbs_pkg::STATUS_IDX:
                    rd_data_next = {13'h0000, st_reg};
                default:                   rd_data_next = 16'h0000;
            endcase
        end
    end

    // Parameter registers.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stop_behaviour_reg          <= dsbs_pkg::STOP_BEH_RST;
            dc_brake_function_reg       <= dsbs_pkg::BRAKE_FN_RST;
            dc_brake_duration_reg       <= dsbs_pkg::BRAKE_DUR_RST;
            dc_brake_voltage_pct_reg    <= dsbs_pkg::BRAKE_VOLT_RST;
            dc_brake_onset_freq_pct_reg <= dsbs_pkg::BRAKE_ONSET_RST;
            rd_data_reg                 <= 16'h0000;
            rd_valid_reg                <= 1'b0;
        end
        else
        begin
            stop_behaviour_reg          <= stop_behaviour_next;
            dc_brake_function_reg       <= dc_brake_function_next;
            dc_brake_duration_reg       <= dc_brake_duration_next;
            dc_brake_voltage_pct_reg    <= dc_brake_voltage_pct_next;
            dc_brake_onset_freq_pct_reg <= dc_brake_onset_freq_pct_next;
            rd_data_reg                 <= rd_data_next;
            rd_valid_reg                <= rd_valid_next;
        end
    end

    // Command source and terminal decoding. The module's switch only
    // counts while the control source leaves the terminals in charge.
    always_comb
    begin
        eff_term_fn = (cfg_module_present
                       && ctrl_source == dsbs_pkg::CTRL_SRC_TERMINAL)
                      ? cfg_mode_switch : terminal_function;
        term_ctl = (ctrl_source == dsbs_pkg::CTRL_SRC_TERMINAL)
                   && (eff_term_fn == dsbs_pkg::TERM_FN_DEFAULT);
        kill = !external_fault_input
               || (term_ctl && run_clockwise && run_counterclockwise);
        run_req = !kill && (term_ctl
                  ? (run_clockwise ^ run_counterclockwise) : remote_run);
        dir_req = term_ctl ? run_counterclockwise : remote_ccw;
        span = span_60hz ? dsbs_pkg::SPAN_60_DHZ : dsbs_pkg::SPAN_50_DHZ;
        // Full scale maps exactly to the span, not one step below it.
        if (!term_ctl)
            target = (remote_freq_dhz > span) ? span : remote_freq_dhz;
        else if (fixed_speed_one)
            target = dsbs_pkg::FIXED_FREQ_DHZ;
        else if (&analog_ref)
            target = span;
        else
            target = 16'((32'(analog_ref) * 32'(span)) >> REF_W);
        brake_stop  = dc_brake_function_reg[dsbs_pkg::FN_STOP_BIT];
        brake_start = dc_brake_function_reg[dsbs_pkg::FN_START_BIT];
        ramped = (stop_behaviour_reg[0] == dsbs_pkg::STOP_RAMPED);
        // Compare by cross-multiplying so no divider is needed.
        at_onset = (32'(freq_reg) * 32'(dsbs_pkg::PCT_MAX))
                   <= (32'(dc_brake_onset_freq_pct_reg) * 32'(span));
    end

    // One rate generator serves both ramps; a zero time steps every cycle.
    always_comb
    begin
        goal     = (st_reg == ST_RAMP_DOWN) ? 16'h0000 : target;
        ramp_up  = goal > freq_reg;
        ramp_en  = (st_reg == ST_RUN || st_reg == ST_RAMP_DOWN)
                   && (goal != freq_reg);
        ramp_den = ACC_W'(ramp_up ? accel_time_ds : decel_time_ds)
                   * ACC_W'(CYC_PER_DS);
    end

    dsbs_ramp_tick #(
        .ACC_W      (ACC_W)
    ) dsbs_ramp_tick_inst (
        .core_clk   (core_clk),
        .rst        (rst),
        .enable     (ramp_en),
        .step_num   (span),
        .period_den (ramp_den),
        .tick       (ramp_tick)
    );

    // Brake timer: a prescaler of tenths of a second and a tenth counter.
    always_comb
    begin
        braking    = (st_reg == ST_PRE_BRAKE) || (st_reg == ST_STOP_BRAKE);
        brake_done = ds_reg >= dc_brake_duration_reg;
        pre_next   = 32'h0000_0000;
        ds_next    = 16'h0000;
        if (braking && !brake_done)
        begin
            if (pre_reg == 32'(CYC_PER_DS - 1))
                ds_next = ds_reg + 16'h0001;
            else
            begin
                pre_next = pre_reg + 32'h0000_0001;
                ds_next  = ds_reg;
            end
        end
    end

    // Run sequence. Fault and interlock cut the output from any state
    // without braking, since the stage may itself be the fault.
    always_comb
    begin
        st_next   = st_reg;
        freq_next = freq_reg;
        ccw_next  = ccw_reg;
        if (ramp_tick)
            freq_next = ramp_up ? freq_reg + 16'h0001 : freq_reg - 16'h0001;
        if (kill)
        begin
            st_next   = ST_IDLE;
            freq_next = 16'h0000;
        end
        else
        begin
            unique case (st_reg)
                ST_IDLE:
                    if (run_req)
                    begin
                        ccw_next = dir_req;
                        st_next  = brake_start ? ST_PRE_BRAKE : ST_RUN;
                    end
                ST_PRE_BRAKE:
                    if (!run_req)
                        st_next = ST_IDLE;
                    else if (brake_done)
                        st_next = ST_RUN;
                ST_RUN:
                    if (!run_req && ramped)
                        st_next = ST_RAMP_DOWN;
                    else if (!run_req)
                    begin
                        freq_next = 16'h0000;
                        st_next = brake_stop ? ST_STOP_BRAKE : ST_IDLE;
                    end
                ST_RAMP_DOWN:
                    if (run_req && dir_req == ccw_reg)
                        st_next = ST_RUN;
                    else if (brake_stop && at_onset)
                    begin
                        freq_next = 16'h0000;
                        st_next   = ST_STOP_BRAKE;
                    end
                    else if (freq_reg == 16'h0000)
                        st_next = ST_IDLE;
                ST_STOP_BRAKE:
                    if (brake_done)
                        st_next = ST_IDLE;
                default:
                    st_next = ST_IDLE;
            endcase
        end
        // Outputs follow the next state so they change with it.
        en_out_next  = (st_next == ST_RUN) || (st_next == ST_RAMP_DOWN);
        brk_out_next = (st_next == ST_PRE_BRAKE)
                       || (st_next == ST_STOP_BRAKE);
        fout_next = ccw_next ? -$signed({1'b0, freq_next})
                             : $signed({1'b0, freq_next});
    end

    // Sequencer registers.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg      <= ST_IDLE;
            freq_reg    <= 16'h0000;
            ccw_reg     <= 1'b0;
            pre_reg     <= 32'h0000_0000;
            ds_reg      <= 16'h0000;
            en_out_reg  <= 1'b0;
            brk_out_reg <= 1'b0;
            fout_reg    <= 17'sh0_0000;
        end
        else
        begin
            st_reg      <= st_next;
            freq_reg    <= freq_next;
            ccw_reg     <= ccw_next;
            pre_reg     <= pre_next;
            ds_reg      <= ds_next;
            en_out_reg  <= en_out_next;
            brk_out_reg <= brk_out_next;
            fout_reg    <= fout_next;
        end
    end

    // Registered outputs; the level reads zero when not braking.
    assign drive_enable      = en_out_reg;
    assign dc_brake_on       = brk_out_reg;
    assign dc_brake_volt_pct = brk_out_reg ? dc_brake_voltage_pct_reg[6:0]
                                           : 7'h00;
    assign out_freq_dhz      = fout_reg;
    assign drive_state       = st_reg;
    assign par_rd_data       = rd_data_reg;
    assign par_rd_valid      = rd_valid_reg;

    // Checks on the sequence.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_run_dropped;
        st_reg == ST_RUN && !run_req && !kill;
    endsequence

    sequence s_in_ramp;
        st_reg == ST_RAMP_DOWN && !run_req && !kill;
    endsequence

    a_interlock_off: assert property (
        term_ctl && run_clockwise && run_counterclockwise
        |=> !drive_enable && out_freq_dhz == 17'sh0_0000)
        else $error("Both run inputs high left the drive on.");

    a_fault_off: assert property (
        !external_fault_input |=> !drive_enable && !dc_brake_on)
        else $error("Fault input low left the drive on.");

    a_ramped_stop: assert property (
        s_run_dropped and ramped |=> st_reg == ST_RAMP_DOWN && drive_enable)
        else $error("Ramped stop did not enter the ramp.");

    a_ramp_falls: assert property (
        s_in_ramp ##1 s_in_ramp |-> freq_reg <= $past(freq_reg))
        else $error("Frequency rose during a ramped stop.");

    a_coast_cut: assert property (
        s_run_dropped and !ramped and !brake_stop
        |=> !drive_enable && !dc_brake_on && freq_reg == 16'h0000)
        else $error("Coasting stop kept driving.");

    a_coast_brake: assert property (
        s_run_dropped and !ramped and brake_stop
        |=> dc_brake_on && st_reg == ST_STOP_BRAKE)
        else $error("Coasting stop with braking did not brake at once.");

    a_onset_brake: assert property (
        s_in_ramp and brake_stop and at_onset |=> dc_brake_on)
        else $error("Braking did not start at the onset frequency.");

    a_brake_volt: assert property (
        dc_brake_on |-> 16'(dc_brake_volt_pct) == dc_brake_voltage_pct_reg)
        else $error("Brake level differs from its setting.");

    a_brake_limit: assert property (
        braking |-> ds_reg <= dc_brake_duration_reg)
        else $error("Brake timer ran past the programmed time.");

    a_brake_expiry: assert property (
        st_reg == ST_STOP_BRAKE && brake_done && !kill
        |=> !dc_brake_on && st_reg == ST_IDLE)
        else $error("Brake output stayed on after expiry.");

    a_fixed_speed: assert property (
        term_ctl && fixed_speed_one |-> target == dsbs_pkg::FIXED_FREQ_DHZ)
        else $error("Fixed speed did not select 20 Hz.");

    a_ccw_sign: assert property (
        drive_enable && ccw_reg && freq_reg != 16'h0000
        |-> out_freq_dhz < 17'sh0_0000)
        else $error("Counterclockwise frequency is not negative.");

endmodule

`default_nettype wire

// [dsbs_term_model.sv]
/*
 * Terminal-side partner: drives the run, fault and fixed-speed contacts.
 * Assumes level commands from the bench; contacts follow one clock later.
 */
`timescale 1ns/1ps
`default_nettype none
module dsbs_term_model (
    input  wire logic core_clk,
    input  wire logic cmd_cw,
    input  wire logic cmd_ccw,
    input  wire logic cmd_fault,
    input  wire logic cmd_ff1,
    output logic      run_clockwise,
    output logic      run_counterclockwise,
    output logic      external_fault_input,
    output logic      fixed_speed_one
);
    // Contacts update a little after the edge to avoid races; the fault
    // contact is inverted, so a healthy line with no fault reads high.
    always @(posedge core_clk)
    begin
        run_clockwise        <= #1 cmd_cw;
        run_counterclockwise <= #1 cmd_ccw;
        external_fault_input <= #1 ~cmd_fault;
        fixed_speed_one      <= #1 cmd_ff1;
    end
endmodule
`default_nettype wire

// [dsbs_sequencer_tb_top.sv]
/*
 * Self-checking bench of the stop and DC brake sequencer.
 * Assumes the terminal model above; the tenth-second count is shortened.
 */
`timescale 1ns/1ps
`default_nettype none
module dsbs_sequencer_tb_top;
    localparam int CYC = 10;
    logic core_clk, rst, wr_en, rd_en, cw, ccw, flt, ff1, span60, rrun, rccw;
    logic run_cw, run_ccw, fault_in, ff_in, par_rd_valid, drive_enable;
    logic dc_brake_on, cmp;
    logic [7:0] addr;
    logic [15:0] wdata, par_rd_data, rfreq;
    logic [9:0] aref;
    logic [3:0] csrc, tfn, cms;
    logic signed [16:0] out_freq_dhz;
    logic [6:0] volt;
    logic [2:0] drive_state;
    int err_count, checks;
    time t0;
    // Free-running core clock, 8 ns period.
    initial
    begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    dsbs_term_model dsbs_term_model_inst (.core_clk(core_clk), .cmd_cw(cw),
        .cmd_ccw(ccw), .cmd_fault(flt), .cmd_ff1(ff1),
        .run_clockwise(run_cw), .run_counterclockwise(run_ccw),
        .external_fault_input(fault_in), .fixed_speed_one(ff_in));
    dsbs_sequencer #(.CYC_PER_DS(CYC)) dsbs_sequencer_inst (
        .core_clk(core_clk), .rst(rst), .par_wr_en(wr_en), .par_rd_en(rd_en),
        .par_addr(addr), .par_wr_data(wdata), .par_rd_data(par_rd_data),
        .par_rd_valid(par_rd_valid), .run_clockwise(run_cw),
        .run_counterclockwise(run_ccw), .external_fault_input(fault_in),
        .fixed_speed_one(ff_in), .analog_ref(aref), .span_60hz(span60),
        .accel_time_ds(16'h0000), .decel_time_ds(16'h0000),
        .ctrl_source(csrc), .terminal_function(tfn),
        .cfg_module_present(cmp), .cfg_mode_switch(cms),
        .remote_run(rrun), .remote_ccw(rccw), .remote_freq_dhz(rfreq),
        .drive_enable(drive_enable), .out_freq_dhz(out_freq_dhz),
        .dc_brake_on(dc_brake_on), .dc_brake_volt_pct(volt),
        .drive_state(drive_state));
    // Compares one value and reports a difference at once.
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Parameter accesses start just after a rising edge and leave one idle
    // edge, so a strobe never drops and rises in the same time step.
    task wr(input logic [7:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr_en = 1;
        cyc(1);
        wr_en = 0;
        cyc(1);
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        addr = a;
        rd_en = 1;
        cyc(1);
        rd_en = 0;
        chk(par_rd_valid, 1);
        chk(par_rd_data, e);
        cyc(1);
        chk(par_rd_valid, 0);
    endtask
    task cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // Bounded wait on frequency (s=0) or brake flag (s=1).
    task wt(input int s, input logic signed [16:0] v);
        int n;
        for (n = 0; n < 3000; n++)
        begin
            if (s == 0 ? out_freq_dhz === v : dc_brake_on === v[0]) break;
            cyc(1);
        end
        chk(n < 3000, 1);
        if (n == 3000) finish_test;
    endtask
    // Main sequence; every stimulus lands 1 ns after a rising edge.
    initial
    begin
        {rst, wr_en, rd_en, cw, ccw, flt, ff1, span60} = 8'b1000_0010;
        {rrun, rccw, addr, wdata, aref, csrc, tfn, cms, cmp} = '0;
        aref = 10'h3FF;
        rfreq = 16'h0032;
        cyc(16);
        rst = 0;
        rd(dsbs_pkg::STOP_BEH_IDX, dsbs_pkg::STOP_BEH_RST);
        rd(8'h00, 16'h0000);
        rd(dsbs_pkg::BRAKE_FN_IDX, dsbs_pkg::BRAKE_FN_RST);
        rd(dsbs_pkg::BRAKE_DUR_IDX, dsbs_pkg::BRAKE_DUR_RST);
        rd(dsbs_pkg::BRAKE_VOLT_IDX, dsbs_pkg::BRAKE_VOLT_RST);
        rd(dsbs_pkg::BRAKE_ONSET_IDX, dsbs_pkg::BRAKE_ONSET_RST);
        wr(dsbs_pkg::BRAKE_FN_IDX, 16'h0004);
        rd(dsbs_pkg::BRAKE_FN_IDX, 16'h0000);
        wr(dsbs_pkg::BRAKE_FN_IDX, 16'h0001);
        wr(dsbs_pkg::BRAKE_DUR_IDX, 16'h0001);
        wr(dsbs_pkg::BRAKE_VOLT_IDX, 16'h0032);
        wr(dsbs_pkg::BRAKE_ONSET_IDX, 16'h0014);
        // Ramped stop from the fixed speed, brake taking over at 10 Hz.
        cw = 1;
        wt(0, 17'sd200);
        cw = 0;
        t0 = $time;
        cyc(50);
        chk(drive_enable, 1);
        wt(1, 1);
        chk(32'(($time - t0) / 8) < 110, 1);
        chk(32'(($time - t0) / 8) > 90, 1);
        chk({drive_enable, out_freq_dhz}, 0);
        chk(volt, 7'd50);
        t0 = $time;
        wt(1, 0);
        chk(32'(($time - t0) / 8), CYC + 1);
        chk(drive_state, 0);
        chk(volt, 7'h00);
        // Reverse run, then the interlock and the fault contact.
        ccw = 1;
        wt(0, -17'sd200);
        cw = 1;
        cyc(3);
        chk({drive_enable, dc_brake_on, drive_state}, 0);
        flt = 1;
        ccw = 0;
        cyc(3);
        chk({drive_enable, drive_state}, 0);
        {flt, cw} = 2'b00;
        cyc(3);
        // Coasting stop with braking before start and on stop.
        wr(dsbs_pkg::STOP_BEH_IDX, 16'h0000);
        wr(dsbs_pkg::BRAKE_FN_IDX, 16'h0003);
        cw = 1;
        wt(1, 1);
        chk(drive_state, 1);
        wt(0, 17'sd200);
        cw = 0;
        cyc(2);
        chk({dc_brake_on, drive_enable}, 2'b10);
        chk(out_freq_dhz, 0);
        wt(1, 0);
        // Analog reference at full span with the 60 Hz range.
        {ff1, span60, cw} = 3'b011;
        wt(0, 17'sd600);
        cw = 0;
        cyc(40);
        // Non-terminal control source takes the remote command.
        {csrc, rrun, rccw} = 6'b0001_11;
        wt(0, -17'sd50);
        // The module switch counts only while the source is the terminals.
        {csrc, cmp, cms} = 9'b0000_1_0001;
        cyc(3);
        chk(out_freq_dhz, -17'sd50);
        cms = 4'h0;
        cyc(3);
        chk(drive_enable, 0);
        wt(1, 0);
        {tfn, cmp} = 5'b0001_0;
        wt(0, -17'sd50);
        finish_test;
    end
endmodule
`default_nettype wire
